// ===== ssp_pkg.sv
`default_nettype none
package ssp_pkg;
  // -----------------------------------------------------------------
  // register indices; byte address is four times the index
  // -----------------------------------------------------------------
  localparam logic [3:0] IDX_TX_PORT    = 4'h2;
  localparam logic [3:0] IDX_CONTROL    = 4'h4;
  localparam logic [3:0] IDX_STATUS     = 4'h6;
  localparam logic [3:0] IDX_FIFO_CTRL  = 4'h8;
  localparam logic [3:0] IDX_FIFO_COUNT = 4'ha;
  // -----------------------------------------------------------------
  // serial_control field positions
  // -----------------------------------------------------------------
  localparam int unsigned CB_RX_EN   = 0;
  localparam int unsigned CB_TX_EN   = 1;
  localparam int unsigned CB_RX_IE   = 2;
  localparam int unsigned CB_TX_IE   = 3;
  localparam int unsigned CB_LEN     = 4;
  localparam int unsigned CB_SE      = 5;
  localparam int unsigned CB_TM      = 6;
  localparam int unsigned CB_RC_IE   = 8;
  localparam int unsigned CB_TC_IE   = 9;
  localparam int unsigned CB_DMA     = 10;
  localparam logic [15:0] CTRL_WMASK = 16'h077f;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // -----------------------------------------------------------------
  // serial_status, fifo_control_reg, fifo_count_reg layouts
  // -----------------------------------------------------------------
  localparam int unsigned SB_TX_LOW   = 1;
  localparam int unsigned SB_UNDERRUN = 3;
  localparam logic [15:0] STAT_RESET  = 16'h0002;
  localparam int unsigned FB_RX_CLR   = 0;
  localparam int unsigned FB_TX_CLR   = 1;
  localparam int unsigned FB_WM_LO    = 12;
  localparam logic [15:0] FCTL_RESET  = 16'h0000;
  localparam int unsigned NB_TX_CNT   = 8;
  // -----------------------------------------------------------------
  // word shape and fifo
  // -----------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned WORD_W     = 16;
  localparam logic [3:0]  LAST_BIT_8  = 4'h7;
  localparam logic [3:0]  LAST_BIT_16 = 4'hf;
  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_SHIFT} ssp_state_t;
endpackage
`default_nettype wire

// ===== ssp_sync2.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;
  // -----------------------------------------------------------------
  // two-flop synchroniser; stage1 feeds only stage two
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
`default_nettype wire

// ===== ssp_fifo_mem.sv
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo_mem #(
  parameter int unsigned W  = 16,
  parameter int unsigned D  = 16,
  parameter int unsigned AW = $clog2(D)
) (
  input  wire logic          mclk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);
  logic [W-1:0] mem [D];
  // -----------------------------------------------------------------
  // storage; read data registered, one cycle behind the address
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== ssp_tx_port.sv
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - sixteen by sixteen bit transmit fifo
// - pop at or below watermark sets flag
// - enable and flag raise transmit request
// - dma write above watermark clears flag
// - fifo empty after reset and clear
// - control resets zero, reserved bits zero
// - routing bit steers data requests dma
// - bits nine, eight gate control interrupts
// - sync source selects pin input or output
// - interval internal sync stops at empty
// - continuous syncs once, interval every word
// - length bit picks eight or sixteen
// - bit two gates receive data request
// - transmit disable floats data, own sync
// - status resets 0002, clear reinitialises flags
// - empty fifo at word start flags underrun
module ssp_tx_port (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [5:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic      [31:0]  avs_readdata,
  output logic              avs_waitrequest,
  input  wire logic         bus_is_dma,
  input  wire logic         tx_sclk_pin,
  input  wire logic         tx_sync_in,
  output logic              tx_sync_out,
  output logic              tx_sync_oe,
  output logic              tx_serial_out,
  output logic              tx_serial_oe,
  input  wire logic         tx_ctrl_empty_flag,
  input  wire logic         rx_ctrl_full_flag,
  input  wire logic         rx_fifo_level_flag,
  output logic              cpu_tx_irq,
  output logic              dma_tx_req,
  output logic              cpu_rx_irq,
  output logic              dma_rx_req,
  output logic              cpu_ctrl_irq,
  output logic              tx_error_irq,
  output logic              rx_enable,
  output logic              word_length,
  output logic              rx_fifo_clear
);
  import ssp_pkg::*;

  localparam int unsigned AW = $clog2(FIFO_DEPTH);

  logic [15:0]       ctrl;
  logic [15:0]       fctl;
  logic              tx_low;
  logic              underrun;
  logic [AW:0]       count;
  logic [AW-1:0]     wr_ptr;
  logic [AW-1:0]     rd_ptr;
  logic [WORD_W-1:0] fifo_rdata;
  logic              last_push;
  logic [AW-1:0]     last_push_addr;
  logic [WORD_W-1:0] last_push_word;
  logic [WORD_W-1:0] shreg;
  logic [3:0]        bit_cnt;
  ssp_state_t        state;
  logic [1:0]        pins_s;
  logic              sclk_d;

  // -----------------------------------------------------------------
  // control field decode
  // -----------------------------------------------------------------
  wire       te        = ctrl[CB_TX_EN];
  wire       tx_irq_enable       = ctrl[CB_TX_IE];
  wire       dl        = ctrl[CB_LEN];
  wire       se        = ctrl[CB_SE];
  wire       tm        = ctrl[CB_TM];
  wire       dma_routing_select     = ctrl[CB_DMA];
  wire       tx_clr    = fctl[FB_TX_CLR];
  wire [3:0] watermark = fctl[FB_WM_LO+3:FB_WM_LO];
  wire [4:0] wm_ext    = {1'b0, watermark};

  // -----------------------------------------------------------------
  // bus decode; one wait cycle, completion when waitrequest is low
  // -----------------------------------------------------------------
  wire       req      = avs_read | avs_write;
  wire [3:0] idx      = avs_address[5:2];
  wire       aligned  = (avs_address[1:0] == 2'b00);
  wire       wr_done  = avs_write & ~avs_waitrequest & aligned;
  wire       wr_tx    = wr_done & (idx == IDX_TX_PORT);
  wire       wr_ctrl  = wr_done & (idx == IDX_CONTROL);
  wire       wr_stat  = wr_done & (idx == IDX_STATUS);
  wire       wr_fctl  = wr_done & (idx == IDX_FIFO_CTRL);
  wire [15:0] lane_m  = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] wdata   = avs_writedata[15:0];
  // 8-bit mode keeps only the low byte of each word
  wire [15:0] tx_word = dl ? wdata : {8'h00, wdata[7:0]};

  // -----------------------------------------------------------------
  // read mux; unmapped and write-only locations read zero
  // -----------------------------------------------------------------
  wire [15:0] stat_view = ({15'h0, tx_low} << SB_TX_LOW)
                        | ({15'h0, underrun} << SB_UNDERRUN);
  wire [15:0] cnt_view  = {11'h0, count} << NB_TX_CNT;
  wire [15:0] rd_sel    = !aligned               ? 16'h0000 :
                          (idx == IDX_CONTROL)    ? ctrl :
                          (idx == IDX_STATUS)     ? stat_view :
                          (idx == IDX_FIFO_CTRL)  ? fctl :
                          (idx == IDX_FIFO_COUNT) ? cnt_view : 16'h0000;

  // -----------------------------------------------------------------
  // link pins sampled through two flops before any use
  // -----------------------------------------------------------------
  ssp_sync2 #(
    .W (2)
  ) u_pin_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({tx_sync_in, tx_sclk_pin}),
    .sync_out (pins_s)
  );

  wire sclk_rise = pins_s[0] & ~sclk_d;
  wire ext_sync  = pins_s[1];

  // -----------------------------------------------------------------
  // word boundary and load decisions
  // -----------------------------------------------------------------
  wire [3:0] last_bit = dl ? LAST_BIT_16 : LAST_BIT_8;
  wire       fifo_any = (count != '0);
  wire       word_end = (state == ST_SHIFT) && (bit_cnt == last_bit);
  // continuous mode chains words with no further sync
  wire       chain    = word_end && !se;
  // external sync taken from the pin only when tm is clear
  wire       ext_go   = (state == ST_IDLE) && !tm && ext_sync;
  wire       load_now = sclk_rise && te && !tx_clr
                      && ((state == ST_SYNC) || ext_go || chain);
  wire       pop      = load_now && fifo_any;
  // starting a word with nothing queued is an underrun
  wire       under_ev = load_now && !fifo_any;
  // interval internal sync only while words are queued
  wire       gen_sync = sclk_rise && te && tm && (state == ST_IDLE)
                      && fifo_any;
  wire       push     = wr_tx && (count < (AW+1)'(FIFO_DEPTH)) && !tx_clr;
  wire [4:0] cnt_next = tx_clr ? 5'h00 : 5'(count + push - pop);

  ssp_fifo_mem #(
    .W (WORD_W),
    .D (FIFO_DEPTH)
  ) u_tx_mem (
    .mclk    (mclk),
    .wr_en   (push),
    .wr_addr (wr_ptr),
    .wr_data (tx_word),
    .rd_addr (rd_ptr),
    .rd_data (fifo_rdata)
  );

  // read register lags a write by one edge; a word written on the last
  // edge is taken from its own copy so a quick load never sends stale data
  wire [WORD_W-1:0] head_word = (last_push && (last_push_addr == rd_ptr))
                              ? last_push_word : fifo_rdata;

  // -----------------------------------------------------------------
  // bus slave handshake and read data
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= {16'h0000, rd_sel};
      end
    end
  end

  // -----------------------------------------------------------------
  // control and fifo control registers
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctrl <= CTRL_RESET;
      fctl <= FCTL_RESET;
    end else begin
      if (wr_ctrl) begin
        // reserved bits never store, so they read zero
        ctrl <= (ctrl & ~(lane_m & CTRL_WMASK)) | (wdata & lane_m & CTRL_WMASK);
      end
      if (wr_fctl) begin
        fctl <= (fctl & ~lane_m) | (wdata & lane_m);
      end
    end
  end

  // -----------------------------------------------------------------
  // fifo pointers and count; clear holds it empty
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n || tx_clr) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      last_push      <= 1'b0;
      last_push_addr <= '0;
      last_push_word <= '0;
    end else begin
      last_push      <= push;
      last_push_addr <= wr_ptr;
      last_push_word <= tx_word;
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= cnt_next;
    end
  end

  // -----------------------------------------------------------------
  // status flags; hardware set beats a software zero write
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n || tx_clr) begin
      tx_low   <= STAT_RESET[SB_TX_LOW];
      underrun <= STAT_RESET[SB_UNDERRUN];
    end else begin
      if (pop && (cnt_next <= wm_ext)) begin
        tx_low <= 1'b1;
      end else if (push && bus_is_dma && (cnt_next > wm_ext)) begin
        tx_low <= 1'b0;
      end else if (wr_stat && avs_byteenable[0] && !wdata[SB_TX_LOW]
                   && (count > wm_ext)) begin
        tx_low <= 1'b0;
      end
      if (under_ev) begin
        underrun <= 1'b1;
      end else if (wr_stat && avs_byteenable[0] && !wdata[SB_UNDERRUN]) begin
        underrun <= 1'b0;
      end
    end
  end

  // -----------------------------------------------------------------
  // transmit engine, stepped on rising serial clock edges
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state       <= ST_IDLE;
      sclk_d      <= 1'b0;
      shreg       <= '0;
      bit_cnt     <= 4'h0;
      tx_sync_out <= 1'b0;
    end else begin
      sclk_d <= pins_s[0];
      if (!te || tx_clr) begin
        state       <= ST_IDLE;
        tx_sync_out <= 1'b0;
      end else if (load_now) begin
        // empty fifo shifts zeros rather than stale data
        shreg       <= fifo_any ? head_word : '0;
        bit_cnt     <= 4'h0;
        state       <= ST_SHIFT;
        tx_sync_out <= 1'b0;
      end else if (gen_sync) begin
        tx_sync_out <= 1'b1;
        state       <= ST_SYNC;
      end else if (sclk_rise && word_end) begin
        state <= ST_IDLE;
      end else if (sclk_rise && (state == ST_SHIFT)) begin
        shreg   <= shreg << 1;
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  // -----------------------------------------------------------------
  // pin drivers and requests, all registered
  // -----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tx_serial_out <= 1'b0;
      tx_serial_oe  <= 1'b0;
      tx_sync_oe    <= 1'b0;
      cpu_tx_irq    <= 1'b0;
      dma_tx_req    <= 1'b0;
      cpu_rx_irq    <= 1'b0;
      dma_rx_req    <= 1'b0;
      cpu_ctrl_irq  <= 1'b0;
      tx_error_irq  <= 1'b0;
      rx_enable     <= 1'b0;
      word_length   <= 1'b0;
      rx_fifo_clear <= 1'b0;
    end else begin
      // msb of the active length leads the word
      tx_serial_out <= dl ? shreg[15] : shreg[7];
      tx_serial_oe  <= te;
      tx_sync_oe    <= te & tm;
      cpu_tx_irq    <= tx_irq_enable & tx_low & ~dma_routing_select;
      dma_tx_req    <= tx_irq_enable & tx_low & dma_routing_select;
      cpu_rx_irq    <= ctrl[CB_RX_IE] & rx_fifo_level_flag & ~dma_routing_select;
      dma_rx_req    <= ctrl[CB_RX_IE] & rx_fifo_level_flag & dma_routing_select;
      // control word events only reach the cpu
      cpu_ctrl_irq  <= (ctrl[CB_TC_IE] & tx_ctrl_empty_flag)
                     | (ctrl[CB_RC_IE] & rx_ctrl_full_flag);
      tx_error_irq  <= underrun;
      rx_enable     <= ctrl[CB_RX_EN];
      word_length   <= dl;
      rx_fifo_clear <= fctl[FB_RX_CLR];
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  fifo_depth_a: assert property (count <= (AW+1)'(FIFO_DEPTH))
    else $error("fifo count above depth");
  low_set_a: assert property (pop && !tx_clr && (cnt_next <= wm_ext) |=> tx_low)
    else $error("empty flag not set on pop at watermark");
  tx_req_a: assert property ((cpu_tx_irq || dma_tx_req) |-> $past(tx_irq_enable && tx_low))
    else $error("transmit request without enable and flag");
  route_a: assert property (dma_tx_req |-> !cpu_tx_irq && $past(dma_routing_select))
    else $error("transmit request routed wrongly");
  dma_clear_a: assert property (push && bus_is_dma && !pop && (cnt_next > wm_ext)
    |=> !tx_low)
    else $error("dma write above watermark left flag set");
  clear_empty_a: assert property (tx_clr |=> count == '0 && tx_low && !underrun)
    else $error("fifo clear did not empty and reinit");
  reserved_a: assert property ((ctrl & ~CTRL_WMASK) == 16'h0000)
    else $error("reserved control bits set");
  sync_oe_a: assert property (##1 tx_sync_oe == $past(te && tm))
    else $error("sync pin enable mismatch");
  sync_stop_a: assert property (tm && se && count == '0 && state == ST_IDLE
    |=> !$rose(tx_sync_out))
    else $error("sync generated with empty fifo");
  underrun_a: assert property (under_ev && !tx_clr |=> underrun ##1 tx_error_irq)
    else $error("underrun not flagged");
  bit_len_a: assert property (state == ST_SHIFT |-> bit_cnt <= last_bit)
    else $error("bit count past word length");
endmodule
`default_nettype wire

// ===== ssp_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// far-end serial device: link clock, frame sync, word capture
// -----------------------------------------------------------------
module ssp_codec_model (
  output logic        sclk,
  output logic        sync_drv,
  output logic        sync_drv_oe,
  input  wire logic   sync_pin,
  input  wire logic   ser_data,
  input  wire logic   ser_oe,
  output logic [15:0] rx_word,
  output logic        rx_valid,
  output int          n_sync
);
  // clock stands low between frames, sync line left to its pull-down
  initial begin
    sclk = 1'b0;
    sync_drv = 1'b0;
    sync_drv_oe = 1'b0;
    rx_word = 16'h0;
    rx_valid = 1'b0;
    n_sync = 0;
  end
  // one frame of 200 ns periods; sampling just before each rise, off
  // the mclk grid, so the device's own updates never race the model
  task automatic run_frame(input bit ext, input bit every, input int nb,
                           input int nw, input int max_e, input int gap);
    int e;
    int b;
    int w;
    bit run;
    run = 1'b0;
    b = 0;
    w = 0;
    #(7 + 100 * gap);
    for (e = 0; e < max_e && w < nw; e++) begin
      rx_valid = 1'b0;
      sync_drv_oe = ext;
      sync_drv = ext && !run;
      #100;
      if (run) begin
        rx_word = {rx_word[14:0], ser_oe ? ser_data : 1'bx};
        b++;
      end
      if (run && b == nb) begin
        rx_valid = 1'b1;
        b = 0;
        w++;
        run = !every;
      end else if (!run && sync_pin) begin
        run = 1'b1;
        rx_word = 16'h0;
        n_sync++;
      end
      sclk = 1'b1;
      #100;
      sclk = 1'b0;
    end
    sync_drv_oe = 1'b0;
    #100;
    rx_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== sync_serial_tx_fifo_control_test.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------
// bench: register bus, request routing, fifo and serial traffic
// -----------------------------------------------------------------
module sync_serial_tx_fifo_control_test;
  import ssp_pkg::*;
  localparam logic [5:0] A_TX  = {IDX_TX_PORT, 2'b00};
  localparam logic [5:0] A_CTL = {IDX_CONTROL, 2'b00};
  localparam logic [5:0] A_ST  = {IDX_STATUS, 2'b00};
  localparam logic [5:0] A_FC  = {IDX_FIFO_CTRL, 2'b00};
  localparam logic [5:0] A_CNT = {IDX_FIFO_COUNT, 2'b00};
  logic        mclk, rst_n, avs_read, avs_write, avs_waitrequest, bus_is_dma;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, r, ex;
  logic [3:0]  avs_byteenable;
  logic        sclk, drv, drv_oe, tx_sync_out, tx_sync_oe, tx_serial_out, tx_serial_oe;
  logic        cpu_tx_irq, dma_tx_req, cpu_rx_irq, dma_rx_req, cpu_ctrl_irq;
  logic        tx_error_irq, word_length, rx_valid, rx_enable, rx_fifo_clear;
  logic [2:0]  side_flags;
  logic [15:0] rx_word;
  wire logic   sync_pin;
  wire logic [5:0] reqs;
  int          n_sync, k;
  int          n_mismatch = 0;
  int          n_checks = 0;
  logic        dma_mode = 1'b0;
  logic [31:0] seed = 32'h96c74deb;
  logic [15:0] exp_rd[$];
  logic [15:0] exp_ser[$];
  // pull-down on the sync line when neither end drives it
  assign sync_pin = tx_sync_oe ? tx_sync_out : (drv_oe ? drv : 1'b0);
  assign reqs = {cpu_tx_irq, dma_tx_req, cpu_rx_irq, dma_rx_req, cpu_ctrl_irq, word_length};
  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  ssp_tx_port ssp_tx_port_i (
    .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .bus_is_dma, .tx_sclk_pin(sclk), .tx_sync_in(sync_pin),
    .tx_sync_out, .tx_sync_oe, .tx_serial_out, .tx_serial_oe,
    .tx_ctrl_empty_flag(side_flags[0]), .rx_ctrl_full_flag(side_flags[1]),
    .rx_fifo_level_flag(side_flags[2]), .cpu_tx_irq, .dma_tx_req, .cpu_rx_irq, .dma_rx_req,
    .cpu_ctrl_irq, .tx_error_irq, .rx_enable, .word_length, .rx_fifo_clear);
  ssp_codec_model ssp_codec_model_i (
    .sclk, .sync_drv(drv), .sync_drv_oe(drv_oe), .sync_pin, .ser_data(tx_serial_out),
    .ser_oe(tx_serial_oe), .rx_word, .rx_valid, .n_sync);
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one transfer, held until waitrequest is seen low; reads note data
  task automatic bus(input bit wr, input logic [5:0] a, input logic [31:0] d,
                     input logic [15:0] e);
    int t;
    t = 0;
    if (!wr) exp_rd.push_back(e);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    bus_is_dma <= dma_mode;
    do begin
      @(posedge mclk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    chk(32'(t < 50), 32'h1, "bus answer");
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    bus_is_dma <= 1'b0;
  endtask
  task automatic put(input logic [31:0] d, input bit l16, input bit dma);
    dma_mode = dma;
    exp_ser.push_back(l16 ? d[15:0] : {8'h0, d[7:0]});
    bus(1'b1, A_TX, d, 16'h0);
  endtask
  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchers take the oldest note whenever a result shows up
  always @(posedge mclk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      chk(avs_readdata, {16'h0, exp_rd.pop_front()}, "read data");
    end
  end
  always @(posedge rx_valid) begin
    chk({16'h0, rx_word}, {16'h0, exp_ser.pop_front()}, "serial word");
  end
  // hang guard: the sequence needs well under 200 us
  initial begin
    #1_000_000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    avs_address = 6'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    bus_is_dma = 1'b0;
    side_flags = 3'h0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values, unmapped and misaligned places, reserved bits
    bus(0, A_CTL, 0, CTRL_RESET);
    bus(0, A_ST, 0, STAT_RESET);
    bus(0, A_CNT, 0, 16'h0);
    bus(0, 6'h3c, 0, 16'h0);
    bus(0, 6'h11, 0, 16'h0);
    bus(1, A_CTL, 32'hffff_fffc, 0);
    bus(0, A_CTL, 0, 16'h077c);
    // every routing and enable combination against random side flags
    for (int i = 0; i < 32; i++) begin
      r = rnd();
      @(posedge mclk);
      side_flags <= r[2:0];
      bus(1, A_CTL, {21'h0, i[4:2], 3'b000, r[3], i[1:0], 2'b00}, 0);
      settle();
      ex = {26'h0, i[1] & !i[4], i[1] & i[4], i[0] & r[2] & !i[4], i[0] & r[2] & i[4],
            (i[3] & r[0]) | (i[2] & r[1]), r[3]};
      chk(32'(reqs), ex, "request routing");
    end
    // dma fills all sixteen stages; flag holds until the mark is passed
    bus(1, A_CTL, 32'h0018, 0);
    bus(1, A_CTL, 32'h001a, 0);
    bus(1, A_FC, 32'hf000, 0);
    for (int i = 0; i < 16; i++) begin
      if (i == 15) bus(0, A_ST, 0, 16'h0002);
      put(rnd(), 1'b1, 1'b1);
    end
    bus(0, A_CNT, 0, 16'h1000);
    bus(0, A_ST, 0, 16'h0000);
    settle();
    chk(32'(cpu_tx_irq), 32'h0, "request after dma fill");
    // one sync, sixteen chained words, then the chain runs dry
    ssp_codec_model_i.run_frame(1, 0, 16, 16, 300, 0);
    settle();
    bus(0, A_ST, 0, 16'h000a);
    chk(32'({cpu_tx_irq, tx_error_irq}), 32'h3, "low and underrun");
    // clearing drops writes and reinitialises the transmit flags
    bus(1, A_FC, 32'hf003, 0);
    bus(1, A_TX, rnd(), 0);
    bus(0, A_ST, 0, STAT_RESET);
    bus(0, A_CNT, 0, 16'h0);
    chk(32'(rx_fifo_clear), 32'h1, "receive clear copy");
    bus(1, A_FC, 32'h2000, 0);
    // byte words in interval mode with the block making its own sync
    bus(1, A_CTL, 32'h0018, 0);
    // control-word mode stays off, so own sync and interval mode are free
    bus(1, A_CTL, 32'h0060, 0);
    settle();
    chk(32'({tx_sync_oe, tx_serial_oe, rx_enable, rx_fifo_clear}), 32'h0, "floating");
    bus(1, A_CTL, 32'h0063, 0);
    settle();
    chk(32'({tx_sync_oe, tx_serial_oe, rx_enable}), 32'h7, "drive when enabled");
    for (int i = 0; i < 3; i++) put(rnd(), 1'b0, 1'b0);
    k = n_sync;
    ssp_codec_model_i.run_frame(0, 1, 8, 3, 60, 2);
    ssp_codec_model_i.run_frame(0, 1, 8, 1, 20, 0);
    chk(32'(n_sync - k), 32'h3, "sync per word, none when empty");
    put(rnd(), 1'b0, 1'b0);
    ssp_codec_model_i.run_frame(0, 1, 8, 1, 40, 1);
    chk(32'(n_sync - k), 32'h4, "sync resumes");
    chk(32'(exp_ser.size()), 32'h0, "words left unsent");
    complete_run();
  end
endmodule
`default_nettype wire
